//--- acqdg_params.svh
/*
  Constants of the acquisition diagnostic checker: register offsets, scan
  modes, reset values and diagnostic codes.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef ACQDG_PARAMS_SVH
`define ACQDG_PARAMS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define ACQDG_OFS_DIAG_CFG     12'h000
`define ACQDG_OFS_SCAN_CTRL    12'h004
`define ACQDG_OFS_THR_SHORT    12'h008
`define ACQDG_OFS_THR_LOW      12'h00c
`define ACQDG_OFS_THR_HIGH     12'h010
`define ACQDG_OFS_CELL_CFG     12'h014
`define ACQDG_OFS_SWITCH_EN    12'h018
`define ACQDG_OFS_SWITCH_ALERT 12'h01c
`define ACQDG_OFS_DIAG_RES_A   12'h020
`define ACQDG_OFS_DIAG_RES_B   12'h024
`define ACQDG_OFS_CONV_CTRL    12'h028
`define ACQDG_OFS_NORM_ALERT   12'h02c

// ****************************************************************
// Diagnostic selector codes and scan modes.
// ****************************************************************
`define ACQDG_DIAG_NONE        4'h0
`define ACQDG_DIAG_AMP_OFS     4'hc
`define ACQDG_DIAG_ZERO        4'ha
`define ACQDG_DIAG_FULL        4'hb
`define ACQDG_DIAG_DAC_QTR     4'h8
`define ACQDG_DIAG_DAC_3QTR    4'h7
`define ACQDG_MODE_SHORT       3'h4
`define ACQDG_MODE_OPEN        3'h5
`define ACQDG_MODE_ODD         3'h6
`define ACQDG_MODE_EVEN        3'h7

// ****************************************************************
// Fixed results, DAC codes and switch patterns.
// ****************************************************************
`define ACQDG_RES_ZERO         14'h0000
`define ACQDG_RES_FULL         14'h3ffc
`define ACQDG_DAC_QTR          10'h100
`define ACQDG_DAC_3QTR         10'h2ff
`define ACQDG_SW_ODD           14'h1555
`define ACQDG_SW_EVEN          14'h2aaa
`define ACQDG_OVS_ONE          3'h0
`define ACQDG_TOP_RST          4'hd

`endif

//--- acqdg_pkg.sv
/*
  Types of the acquisition diagnostic checker.
  Assumes acqdg_params.svh is on the include path.
*/
`include "acqdg_params.svh"

package acqdg_pkg;

  typedef enum logic [1:0]
  {
    ACQDG_IDLE = 2'b00,
    ACQDG_SCAN = 2'b01,
    ACQDG_WAIT = 2'b10
  } acqdg_state_t;

  typedef logic [13:0] acqdg_word_t;

endpackage

//--- acqdg_cmp_if.sv
/*
  Interface between the scan sequencer and the threshold comparator.
  Assumes both ends share the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface acqdg_cmp_if;
  logic [2:0]          mode;
  acqdg_pkg::acqdg_word_t result;
  acqdg_pkg::acqdg_word_t thr_short;
  acqdg_pkg::acqdg_word_t thr_low;
  acqdg_pkg::acqdg_word_t thr_high;
  logic                fault;

  modport seq (output mode, output result, output thr_short, output thr_low,
               output thr_high, input fault);
  modport cmp (input mode, input result, input thr_short, input thr_low,
               input thr_high, output fault);
endinterface

`default_nettype wire

//--- acqdg_compare.sv
/*
  Threshold comparator for one switch diagnostic result.
  Assumes a result and thresholds presented by the sequencer in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acqdg_params.svh"

module acqdg_compare
(
  // Compare channel.
  acqdg_cmp_if.cmp c
);

  // Short mode uses the short threshold, other modes the window; strict.
  always_comb
  begin
    if (c.mode == `ACQDG_MODE_SHORT)
      c.fault = (c.result < c.thr_short);                          // [R16] [R24]
    else
      c.fault = (c.result < c.thr_low) || (c.result > c.thr_high); // [R16] [R24]
  end

endmodule

`default_nettype wire

//--- acqdg_checker.sv
/*
  Acquisition diagnostic checker: APB register file, diagnostic slot routing
  and automatic balancing switch diagnostic scans.
  Assumes a converter that answers conv_start with conv_valid and a 14-bit result.
*/
// Local design decisions: the address map and register access over APB.
//
// Contract
// R1: Code 0xc shorts amplifier, bipolar, stores result.
// R2: Amplifier offset slot skips the chopping phase.
// R3: Host range-checks amplifier offset result.
// R4: Host range-checks thermistor offset result.
// R5: Code 0xa forces bipolar, negative rail, 0000h.
// R6: Code 0xb forces bipolar, positive rail, 3ffch.
// R7: Scale-check enable adds end-of-scan scale check.
// R8: Quarter-scale check loads DAC with 0x100.
// R9: Host range-checks quarter-scale DAC result.
// R10: Three-quarter check loads DAC with 2ffh.
// R11: Host range-checks three-quarter DAC result.
// R12: Scan modes 4..7 select switch diagnostics.
// R13: Switch mode configures acquisition; host starts.
// R14: Switch scan request clears alert field.
// R15: Alerts written at scan complete, then held.
// R16: Short below short threshold; else window.
// R17: Summary is OR of fourteen alerts.
// R18: Equal top cells mask alerts above them.
// R19: Summary clears on clean scan or write.
// R20: Normal alerts untouched during switch scans.
// R21: Short mode: switches off, unipolar enabled cells.
// R22: Host refreshes short threshold with margin.
// R23: Short scan forces oversample one, no diagnostics.
// R24: Comparisons are strict; equal raises nothing.
// R25: Alerts reset to zero, change at boundaries.
//
`timescale 1ns/1ps
`default_nettype none
`include "acqdg_params.svh"

module acqdg_checker
#(
  parameter int NCELL = 14
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter control.
  output logic             conv_start,
  output logic             conv_bipolar,
  output logic             conv_no_chop,
  output logic [3:0]       conv_channel,
  output logic [1:0]       conv_input_sel,
  output logic [9:0]       dac_code,
  output logic             alt_mux_path,
  output logic [2:0]       oversample_rate,
  output logic [13:0]      switch_drive,
  output logic             scale_check_run,
  input  wire logic        conv_valid,
  input  wire logic [13:0] conv_result,
  // Normal cell alerts from the measurement checker.
  input  wire logic [2:0]  norm_alert_in,
  // Status.
  output logic             scan_complete,
  output logic             switch_alert_summary
);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [3:0]  diag_select_a_q, diag_select_b_q;
  logic        converter_cal_enable_q, scale_check_at_scan_end_q;
  logic [2:0]  scan_config_mode_q, ovs_cfg_q;
  logic [13:0] thr_short_q, thr_low_q, thr_high_q;
  logic [3:0]  top_cell_a_q, top_cell_b_q;
  logic [13:0] cell_enable_bits_q, cell_bipolar_flag_q, switch_enable_bits_q;
  logic [13:0] switch_alert_bits_q, alert_acc_q, scan_mask_q;
  logic [13:0] diag_result_a_q, diag_result_b_q;
  logic [2:0]  norm_alert_q;
  logic [3:0]  chan_q;
  logic [1:0]  slot_q;
  logic        scan_sw_q;
  acqdg_pkg::acqdg_state_t state_q;

  logic        wr, rd, start_req;
  logic [13:0] top_mask;
  logic        sw_mode;
  acqdg_cmp_if cmp_ch ();

  assign wr        = psel && penable && pwrite;
  assign rd        = psel && !penable && !pwrite;
  assign sw_mode   = scan_config_mode_q[2];                                  // [R12]
  assign start_req = wr && paddr == `ACQDG_OFS_SCAN_CTRL && pwdata[8]
                     && state_q == acqdg_pkg::ACQDG_IDLE;                    // [R13]

  // Masks positions above the top cell when both settings agree.
  function automatic logic [13:0] above_mask(input logic [3:0] a, input logic [3:0] b);
    logic [13:0] m;
    m = 14'h3fff;
    if (a == b)
      for (int i = 0; i < 14; i++)
        m[i] = (i <= int'(a));                                               // [R18]
    return m;
  endfunction

  assign top_mask = above_mask(top_cell_a_q, top_cell_b_q);

  // ****************************************************************
  // APB: zero wait state; unmapped reads return zero with pslverr.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (rd)
      begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `ACQDG_OFS_DIAG_CFG:     prdata <= {23'h0, scale_check_at_scan_end_q,
                                              diag_select_b_q, diag_select_a_q};
          `ACQDG_OFS_SCAN_CTRL:    prdata <= {20'h0, state_q != acqdg_pkg::ACQDG_IDLE,
                                              scan_complete, 3'h0, ovs_cfg_q,
                                              converter_cal_enable_q, scan_config_mode_q};
          `ACQDG_OFS_THR_SHORT:    prdata <= {18'h0, thr_short_q};
          `ACQDG_OFS_THR_LOW:      prdata <= {18'h0, thr_low_q};
          `ACQDG_OFS_THR_HIGH:     prdata <= {18'h0, thr_high_q};
          `ACQDG_OFS_CELL_CFG:     prdata <= {2'h0, cell_bipolar_flag_q, 8'h00,
                                              top_cell_b_q, top_cell_a_q};
          `ACQDG_OFS_SWITCH_EN:    prdata <= {2'h0, cell_enable_bits_q, 2'h0, switch_enable_bits_q};
          `ACQDG_OFS_SWITCH_ALERT: prdata <= {15'h0, switch_alert_summary, 2'h0,
                                              switch_alert_bits_q};
          `ACQDG_OFS_DIAG_RES_A:   prdata <= {16'h0, diag_result_a_q, 2'h0};
          `ACQDG_OFS_DIAG_RES_B:   prdata <= {16'h0, diag_result_b_q, 2'h0};
          `ACQDG_OFS_CONV_CTRL:    prdata <= {22'h0, dac_code};
          `ACQDG_OFS_NORM_ALERT:   prdata <= {29'h0, norm_alert_q};
          default:                 pslverr <= 1'b1;
        endcase
      end
      else if (psel && !penable)
        pslverr <= !(paddr <= `ACQDG_OFS_NORM_ALERT && paddr[1:0] == 2'b00);
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      diag_select_a_q           <= `ACQDG_DIAG_NONE;
      diag_select_b_q           <= `ACQDG_DIAG_NONE;
      scale_check_at_scan_end_q <= 1'b0;
      scan_config_mode_q        <= 3'h0;
      converter_cal_enable_q    <= 1'b0;
      ovs_cfg_q                 <= `ACQDG_OVS_ONE;
      thr_short_q               <= 14'h0000;
      thr_low_q                 <= 14'h0000;
      thr_high_q                <= 14'h3fff;
      top_cell_a_q              <= `ACQDG_TOP_RST;
      top_cell_b_q              <= `ACQDG_TOP_RST;
      cell_bipolar_flag_q       <= 14'h0000;
      cell_enable_bits_q        <= 14'h3fff;
      switch_enable_bits_q      <= 14'h0000;
    end
    else if (wr && state_q == acqdg_pkg::ACQDG_IDLE)
    begin
      case (paddr)
        `ACQDG_OFS_DIAG_CFG:
        begin
          diag_select_a_q           <= pwdata[3:0];
          diag_select_b_q           <= pwdata[7:4];
          scale_check_at_scan_end_q <= pwdata[8];
        end
        `ACQDG_OFS_SCAN_CTRL:
        begin
          scan_config_mode_q     <= pwdata[2:0];
          converter_cal_enable_q <= pwdata[3];
          ovs_cfg_q              <= pwdata[6:4];
        end
        `ACQDG_OFS_THR_SHORT: thr_short_q <= pwdata[13:0];
        `ACQDG_OFS_THR_LOW:   thr_low_q   <= pwdata[13:0];
        `ACQDG_OFS_THR_HIGH:  thr_high_q  <= pwdata[13:0];
        `ACQDG_OFS_CELL_CFG:
        begin
          top_cell_a_q        <= pwdata[3:0];
          top_cell_b_q        <= pwdata[7:4];
          cell_bipolar_flag_q <= pwdata[29:16];
        end
        `ACQDG_OFS_SWITCH_EN:
        begin
          switch_enable_bits_q <= pwdata[13:0];
          cell_enable_bits_q   <= pwdata[29:16];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Scan sequencer: slot 0 channels, slot 1/2 diagnostics, slot 3 scale.
  // ****************************************************************
  logic [3:0] cur_diag;
  assign cur_diag = (slot_q == 2'd1) ? diag_select_a_q : diag_select_b_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q       <= acqdg_pkg::ACQDG_IDLE;
      chan_q        <= 4'h0;
      slot_q        <= 2'd0;
      scan_sw_q     <= 1'b0;
      scan_mask_q   <= 14'h0000;
      conv_start    <= 1'b0;
      scan_complete <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      case (state_q)
        acqdg_pkg::ACQDG_IDLE:
        begin
          if (start_req)
          begin
            scan_complete <= 1'b0;
            scan_sw_q     <= pwdata[2];
            chan_q        <= 4'h0;
            slot_q        <= 2'd0;
            state_q       <= acqdg_pkg::ACQDG_SCAN;
            // Measured positions: short and normal scans use enabled cells, other modes the switches.
            if (pwdata[2:0] == `ACQDG_MODE_SHORT)
              scan_mask_q <= cell_enable_bits_q & ~cell_bipolar_flag_q;      // [R21]
            else if (pwdata[2:0] == `ACQDG_MODE_ODD)
              scan_mask_q <= `ACQDG_SW_ODD & ~cell_bipolar_flag_q & top_mask;
            else if (pwdata[2:0] == `ACQDG_MODE_EVEN)
              scan_mask_q <= `ACQDG_SW_EVEN & ~cell_bipolar_flag_q & top_mask;
            else if (pwdata[2:0] == `ACQDG_MODE_OPEN)
              scan_mask_q <= switch_enable_bits_q & ~cell_bipolar_flag_q;
            else
              scan_mask_q <= cell_enable_bits_q;
          end
        end
        acqdg_pkg::ACQDG_SCAN:
        begin
          if (slot_q == 2'd0 && !scan_mask_q[chan_q] && chan_q != 4'd13)
            chan_q <= chan_q + 4'd1;
          else if (slot_q == 2'd0 && !scan_mask_q[chan_q])
            slot_q <= 2'd1;
          else if (slot_q == 2'd1 && (scan_sw_q || diag_select_a_q == `ACQDG_DIAG_NONE))
            slot_q <= 2'd2;                                                  // [R23]
          else if (slot_q == 2'd2 && (scan_sw_q || diag_select_b_q == `ACQDG_DIAG_NONE))
            slot_q <= 2'd3;                                                  // [R23]
          else if (slot_q == 2'd3 && !scale_check_at_scan_end_q)
          begin
            state_q       <= acqdg_pkg::ACQDG_IDLE;
            scan_complete <= 1'b1;
          end
          else
          begin
            conv_start <= 1'b1;
            state_q    <= acqdg_pkg::ACQDG_WAIT;
          end
        end
        acqdg_pkg::ACQDG_WAIT:
        begin
          if (conv_valid)
          begin
            state_q <= acqdg_pkg::ACQDG_SCAN;
            if (slot_q == 2'd0 && chan_q != 4'd13)
              chan_q <= chan_q + 4'd1;
            else if (slot_q == 2'd3)
            begin
              state_q       <= acqdg_pkg::ACQDG_IDLE;
              scan_complete <= 1'b1;                                         // [R7]
            end
            else
              slot_q <= slot_q + 2'd1;
          end
        end
        default: state_q <= acqdg_pkg::ACQDG_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Converter routing for the current slot.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      conv_bipolar    <= 1'b0;
      conv_no_chop    <= 1'b0;
      conv_channel    <= 4'h0;
      conv_input_sel  <= 2'd0;
      dac_code        <= 10'h000;
      alt_mux_path    <= 1'b0;
      oversample_rate <= `ACQDG_OVS_ONE;
      switch_drive    <= 14'h0000;
      scale_check_run <= 1'b0;
    end
    else
    begin
      conv_channel    <= chan_q;
      alt_mux_path    <= scan_sw_q && state_q != acqdg_pkg::ACQDG_IDLE;     // [R13]
      oversample_rate <= scan_sw_q ? `ACQDG_OVS_ONE : ovs_cfg_q;            // [R23]
      scale_check_run <= slot_q == 2'd3 && state_q != acqdg_pkg::ACQDG_IDLE; // [R7]
      conv_bipolar    <= 1'b0;
      conv_no_chop    <= 1'b0;
      conv_input_sel  <= 2'd0;
      if (state_q == acqdg_pkg::ACQDG_IDLE)
        switch_drive <= switch_enable_bits_q;
      else if (scan_config_mode_q == `ACQDG_MODE_SHORT)
        switch_drive <= 14'h0000;                                            // [R21]
      else if (sw_mode)
        switch_drive <= scan_mask_q;
      if (slot_q == 2'd0 && scan_sw_q && scan_config_mode_q != `ACQDG_MODE_SHORT)
        conv_bipolar <= 1'b1;
      if (slot_q == 2'd1 || slot_q == 2'd2)
      begin
        case (cur_diag)
          `ACQDG_DIAG_AMP_OFS:
          begin
            conv_bipolar   <= 1'b1;                                          // [R1]
            conv_no_chop   <= 1'b1;                                          // [R2]
            conv_input_sel <= 2'd1;
          end
          `ACQDG_DIAG_ZERO:
          begin
            conv_bipolar   <= 1'b1;                                          // [R5]
            conv_input_sel <= 2'd2;
          end
          `ACQDG_DIAG_FULL:
          begin
            conv_bipolar   <= 1'b1;                                          // [R6]
            conv_input_sel <= 2'd3;
          end
          `ACQDG_DIAG_DAC_QTR:  dac_code <= `ACQDG_DAC_QTR;                  // [R8]
          `ACQDG_DIAG_DAC_3QTR: dac_code <= `ACQDG_DAC_3QTR;                 // [R10]
          default:
          begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Results and alerts.
  // ****************************************************************
  assign cmp_ch.mode      = scan_config_mode_q;
  assign cmp_ch.result    = conv_result;
  assign cmp_ch.thr_short = thr_short_q;
  assign cmp_ch.thr_low   = thr_low_q;
  assign cmp_ch.thr_high  = thr_high_q;

  acqdg_compare u_cmp
  (
    .c (cmp_ch)
  );

  logic [13:0] fixed_res;
  always_comb
  begin
    fixed_res = conv_result;
    if (cur_diag == `ACQDG_DIAG_ZERO)
      fixed_res = `ACQDG_RES_ZERO;                                           // [R5]
    else if (cur_diag == `ACQDG_DIAG_FULL)
      fixed_res = `ACQDG_RES_FULL;                                           // [R6]
  end

  logic take;
  assign take = state_q == acqdg_pkg::ACQDG_WAIT && conv_valid;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      diag_result_a_q      <= 14'h0000;
      diag_result_b_q      <= 14'h0000;
      alert_acc_q          <= 14'h0000;
      switch_alert_bits_q  <= 14'h0000;                                      // [R25]
      switch_alert_summary <= 1'b0;
      norm_alert_q         <= 3'h0;
    end
    else
    begin
      if (take && slot_q == 2'd1)
        diag_result_a_q <= fixed_res;                                        // [R1]
      if (take && slot_q == 2'd2)
        diag_result_b_q <= fixed_res;                                        // [R1]
      if (start_req && pwdata[2])
      begin
        alert_acc_q         <= 14'h0000;
        switch_alert_bits_q <= 14'h0000;                                     // [R14]
      end
      else if (take && slot_q == 2'd0 && scan_sw_q && cmp_ch.fault)
        alert_acc_q[chan_q] <= 1'b1;
      if (state_q != acqdg_pkg::ACQDG_IDLE && !scan_sw_q)
        norm_alert_q <= norm_alert_in;                                       // [R20]
      if (scan_sw_q && state_q != acqdg_pkg::ACQDG_IDLE && !scan_complete
          && (take && slot_q == 2'd3 || slot_q == 2'd3 && !scale_check_at_scan_end_q))
      begin
        switch_alert_bits_q  <= alert_acc_q & top_mask;                      // [R15] [R18]
        switch_alert_summary <= |(alert_acc_q & top_mask);                   // [R17] [R19]
      end
      else if (wr && paddr == `ACQDG_OFS_SWITCH_ALERT && !pwdata[16])
        switch_alert_summary <= 1'b0;                                        // [R19]
    end
  end

endmodule

`default_nettype wire

//--- acqdg_checker_sva.sv
/*
  Port checks of the acquisition diagnostic checker.
  Assumes it is bound onto acqdg_checker and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module acqdg_checker_sva
(
  // Clock, reset and bus.
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  // Converter and status.
  input wire logic       conv_start,
  input wire logic       conv_bipolar,
  input wire logic       conv_no_chop,
  input wire logic [1:0] conv_input_sel,
  input wire logic [9:0] dac_code,
  input wire logic       scan_complete,
  input wire logic       switch_alert_summary
);
  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("pready missing after setup");
  a_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_start_one_cycle: assert property (conv_start |=> !conv_start)
    else $error("conv_start held");
  a_amp_short_route: assert property (conv_input_sel == 2'h1 |-> conv_bipolar && conv_no_chop)
    else $error("amplifier route wrong");
  a_nochop_only_amp: assert property (conv_no_chop |-> conv_input_sel == 2'h1)
    else $error("no_chop off amplifier slot");
  a_rail_bipolar: assert property (conv_input_sel[1] |-> conv_bipolar)
    else $error("rail slot not bipolar");
  a_dac_code_set: assert property ($changed(dac_code) |-> dac_code == 10'h100 || dac_code == 10'h2ff)
    else $error("unexpected dac code");
  a_summary_cause: assert property ($changed(switch_alert_summary) |-> scan_complete || $past(pready && pwrite))
    else $error("stray summary change");
endmodule

bind acqdg_checker acqdg_checker_sva u_sva (.*);

`default_nettype wire

//--- acqdg_conv_model.sv
/*
  Converter model answering conv_start with one result.
  Assumes rail and shorted inputs give fixed codes, channels a ramp.
*/
`timescale 1ns/1ps
`default_nettype none

module acqdg_conv_model
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Request and answer.
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_channel,
  input  wire logic [1:0]  conv_input_sel,
  output logic             conv_valid,
  output logic [13:0]      conv_result
);
  // ****************************************************************
  // Conversion.
  // ****************************************************************
  logic [13:0] val_q;
  logic [3:0]  cnt_q;
  logic        busy_q;
  logic        slow_q;

  // Prompt and slow answers alternate; idle results toggle.
  always_ff @(posedge clk)
  begin
    conv_valid <= 1'b0;
    conv_result <= ~conv_result;
    if (srst)
    begin
      busy_q <= 1'b0;
      slow_q <= 1'b0;
      conv_result <= 14'h0000;
    end
    else if (conv_start)
    begin
      busy_q <= 1'b1;
      cnt_q <= slow_q ? 4'h9 : 4'h0;
      slow_q <= ~slow_q;
      val_q <= conv_input_sel == 2'h2 ? 14'h0000 : conv_input_sel == 2'h3 ? 14'h3ffc :
               conv_input_sel == 2'h1 ? 14'h2010 :
               14'h0ffe + 14'(conv_channel);
    end
    else if (busy_q && cnt_q == 4'h0)
    begin
      busy_q <= 1'b0;
      conv_valid <= 1'b1;
      conv_result <= val_q;
    end
    else if (busy_q)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule

`default_nettype wire

//--- tb_top.sv
/*
  Testbench of the acquisition diagnostic checker.
  Assumes the design, converter model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  norm_alert_in = 3'h7;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, seen, conv_start, conv_bipolar, conv_no_chop;
  logic        alt_mux_path, scale_check_run, conv_valid, scan_complete, switch_alert_summary;
  logic [3:0]  conv_channel;
  logic [1:0]  conv_input_sel;
  logic [9:0]  dac_code;
  logic [2:0]  oversample_rate;
  logic [13:0] switch_drive, conv_result;
  logic [13:0] drv [4] = '{14'h0000, 14'h3fff, 14'h1555, 14'h2aaa};
  int          err_total = 0;
  int          checks = 0;

  always #50 clk = ~clk;
  acqdg_checker u_dut (.*);
  acqdg_conv_model u_conv (.*);

  task automatic tally_and_finish;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      if (++n > 20)
      begin
        err_total++;
        tally_and_finish();
      end
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // Runs one scan; ck checks switch routing at each conversion.
  task automatic scan(input logic [31:0] ctl, input logic [13:0] dv, input logic ck, input logic e);
    int n = 0;
    apb(1'b1, 12'h004, ctl);
    if (e)
      rdc(12'h01c, 32'h0, "alert_clear");
    seen = 1'b0;
    @(posedge clk);
    while (scan_complete !== 1'b1)
    begin
      if (++n > 5000)
      begin
        err_total++;
        tally_and_finish();
      end
      if (ck && conv_start === 1'b1)
      begin
        chk("switch_drive", 32'(dv), 32'(switch_drive));
        chk("alt_mux", 32'h1, 32'(alt_mux_path));
        chk("oversample", 32'h0, 32'(oversample_rate));
      end
      seen |= scale_check_run === 1'b1;
      @(posedge clk);
    end
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(12'h01c, 32'h0, "alert_reset");
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", 32'h1, 32'(er));
    $display("test registers done");
    apb(1'b1, 12'h000, 32'h000000ba);
    scan(32'h130, 14'h0, 1'b0, 1'b0);
    rdc(12'h020, 32'h0, "diag_zero");
    rdc(12'h024, 32'h0000fff0, "diag_full");
    rdc(12'h02c, 32'h7, "norm_capture");
    apb(1'b1, 12'h000, 32'h0000018c);
    scan(32'h130, 14'h0, 1'b0, 1'b0);
    rdc(12'h020, 32'h00008040, "diag_amp");
    rdc(12'h028, 32'h100, "dac_quarter");
    chk("scale_run", 32'h1, 32'(seen));
    apb(1'b1, 12'h000, 32'h7);
    scan(32'h130, 14'h0, 1'b0, 1'b0);
    rdc(12'h028, 32'h2ff, "dac_three_q");
    $display("test diagnostic slots done");
    norm_alert_in <= 3'h0;
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, 12'h010, 32'h3fff);
    apb(1'b1, 12'h014, 32'h000000dd);
    apb(1'b1, 12'h018, 32'h3fff3fff);
    for (int m = 4; m < 8; m++)
    begin
      scan(32'h130 | 32'(m), drv[m-4], 1'b1, 1'b0);
      rdc(12'h01c, 32'h0, "alerts_edge");
    end
    rdc(12'h02c, 32'h7, "norm_hold");
    $display("test switch modes done");
    apb(1'b1, 12'h008, 32'h1000);
    apb(1'b1, 12'h014, 32'h000200dd);
    scan(32'h134, 14'h0, 1'b1, 1'b0);
    rdc(12'h01c, 32'h00010001, "short_alerts");
    apb(1'b1, 12'h01c, 32'h0);
    rdc(12'h01c, 32'h1, "summary_write");
    apb(1'b1, 12'h00c, 32'h0fff);
    apb(1'b1, 12'h010, 32'h1001);
    apb(1'b1, 12'h014, 32'h00000044);
    scan(32'h135, 14'h0, 1'b0, 1'b1);
    rdc(12'h01c, 32'h00010011, "open_masked");
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, 12'h010, 32'h3fff);
    scan(32'h135, 14'h0, 1'b0, 1'b0);
    rdc(12'h01c, 32'h0, "clean_scan");
    $display("test switch alerts done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
